// ---- hdl/rail_supervisor.sv ----
// Supervision logic: clock select, soft-start, switch sequencing, protection, resets
//
// Summary of operation
// RL1: Idle sync input means internal 750kHz oscillator.
// RL2: Lock to external clock on first edge.
// RL3: Two missed 1.3us periods revert to internal.
// RL4: Enable rise starts 5.5ms soft-start ramp.
// RL5: Sync input ignored during soft-start.
// RL6: Enable low shuts buck switches and oscillator.
// RL7: High on, current trip, dead time, low on.
// RL8: Buck good only enabled and within window.
// RL9: Second buck good output is the inverse.
// RL10: Per cycle: overcurrent adds two, else minus one.
// RL11: Count 1111 shuts buck, resets soft-start.
// RL12: After 16 clocks restart with soft-start.
// RL13: 32 overvoltage cycles shut the buck off.
// RL14: Overvoltage latch clears only on enable/supply toggle.
// RL15: Linear good low when either output off.
// RL16: Linear good low while linears disabled.
// RL17: Reset asserted on low supply, then held.
// RL18: Complementary push-pull reset outputs.
// RL19: Lockout keeps converter off below 2.6V.
// RL20: Reset asserts before lockout shuts outputs.
// RL21: Linear enable low shuts both linears.
// RL22: Both enables low means full-chip shutdown.
// RL23: Reset hold scales 2.5ms per nF.
// RL24: Protection counters step on switching clock.
`timescale 1ns/1ps
module rail_supervisor
  import rail_seq_pkg::*;
#(
  parameter int SS_CYC = SS_CYC_DEF,
  parameter int RST_CYC_PER_NF = RST_CYC_PER_NF_DEF
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from the analog side and host
  input wire pin_in_type pins,
  // Buck power stage
  output logic high_side_on,
  output logic low_side_on,
  output logic ref_internal,
  output logic ss_active,
  // Status outputs
  output logic buck_output_good,
  output logic buck_output_bad,
  output logic linear_output_good_out,
  output logic linear_output_good_oe_n,
  output logic linear_on,
  output logic chip_shutdown,
  output logic reset_n_out,
  output logic reset_out
);

  pin_in_type sync1_r;
  pin_in_type sync2_r;
  logic sync_prev_r;
  buck_state_type buck_r;
  sw_state_type sw_r;
  logic ext_sel_r;
  logic [9:0] loss_cnt_r;
  logic [8:0] osc_cnt_r;
  logic [12:0] ss_cnt_r;
  logic [3:0] oc_cnt_r;
  logic [5:0] ov_cnt_r;
  logic [4:0] restart_cnt_r;
  logic [2:0] dead_cnt_r;
  logic en_prev_r;
  logic [39:0] hold_cnt_r;
  logic [31:0] ctrl_r;
  logic [7:0] cap_nf_r;
  logic [3:0] oc_nxt;

  logic sync_rise;
  logic osc_wrap;
  logic tick;
  logic buck_allowed;
  logic [39:0] hold_target;
  logic apb_setup;
  logic apb_write;
  logic stage_live;

  // Two-flop synchronisers on every pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync_prev_r <= 1'b0;
    end
    else
    begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      sync_prev_r <= sync2_r.sync_clk;
    end
  end

  assign sync_rise = sync2_r.sync_clk && !sync_prev_r;
  assign buck_allowed = sync2_r.buck_enable && !sync2_r.supply_lockout; // [RL19]
  assign osc_wrap = (osc_cnt_r == 9'(INT_PERIOD_CYC - 1));
  // One switching cycle boundary from whichever source is selected
  assign tick = ext_sel_r ? sync_rise : osc_wrap;
  // Drives cut on the trip or disable itself, not a cycle later via sw_r
  assign stage_live = buck_allowed && (buck_r == BUCK_SOFT || buck_r == BUCK_RUN); // [RL6]

  // Internal oscillator, stopped while the buck is disabled or locked out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_cnt_r <= '0;
    else if (!buck_allowed || osc_wrap)
      osc_cnt_r <= '0; // [RL6]
    else
      osc_cnt_r <= osc_cnt_r + 9'h001; // [RL1]
  end

  // Clock source select with loss-of-clock fallback
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_sel_r <= 1'b0;
      loss_cnt_r <= '0;
    end
    else if (buck_r != BUCK_RUN || !ctrl_r[CTRL_SYNC_EN])
    begin
      ext_sel_r <= 1'b0; // [RL5]
      loss_cnt_r <= '0;
    end
    else if (sync_rise)
    begin
      ext_sel_r <= 1'b1; // [RL2]
      loss_cnt_r <= '0;
    end
    else if (loss_cnt_r == 10'(LOSS_CYC - 1))
    begin
      ext_sel_r <= 1'b0; // [RL3]
      loss_cnt_r <= '0;
    end
    else
      loss_cnt_r <= loss_cnt_r + 10'h001;
  end

  // Buck sequencing state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buck_r <= BUCK_OFF;
      en_prev_r <= 1'b0;
    end
    else
    begin
      en_prev_r <= buck_allowed;
      if (!buck_allowed)
        buck_r <= BUCK_OFF; // [RL6] [RL14]
      else
      begin
        case (buck_r)
          BUCK_OFF:
            if (!en_prev_r)
              buck_r <= BUCK_SOFT; // [RL4]
          BUCK_SOFT,
          BUCK_RUN:
            if (tick && ov_cnt_r == OV_CLKS - 6'h01 && sync2_r.over_voltage)
              buck_r <= BUCK_OV_LATCH; // [RL13]
            else if (tick && oc_nxt == OC_MAX)
              buck_r <= BUCK_OC_WAIT; // [RL11]
            else if (buck_r == BUCK_SOFT && tick && ss_cnt_r == 13'(SS_CYC - 1))
              buck_r <= BUCK_RUN; // [RL4]
          BUCK_OC_WAIT:
            if (tick && restart_cnt_r == RESTART_CLKS - 5'h01)
              buck_r <= BUCK_SOFT; // [RL12]
          BUCK_OV_LATCH:
            buck_r <= BUCK_OV_LATCH; // [RL14]
          default:
            buck_r <= BUCK_OFF;
        endcase
      end
    end
  end

  // Soft-start counter, cleared whenever the buck is not ramping
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ss_cnt_r <= '0;
    else if (buck_r != BUCK_SOFT)
      ss_cnt_r <= '0; // [RL11] [RL13]
    else if (tick)
      ss_cnt_r <= ss_cnt_r + 13'h0001;
  end

  // Overcurrent counter: up two, down one, saturating both ways
  always_comb
  begin
    oc_nxt = oc_cnt_r;
    if (sync2_r.over_current)
      oc_nxt = (oc_cnt_r >= OC_MAX - OC_UP) ? OC_MAX : oc_cnt_r + OC_UP; // [RL10]
    else if (oc_cnt_r != 4'h0)
      oc_nxt = oc_cnt_r - 4'h1; // [RL10]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      oc_cnt_r <= '0;
    else if (buck_r != BUCK_SOFT && buck_r != BUCK_RUN)
      oc_cnt_r <= '0;
    else if (tick)
      oc_cnt_r <= oc_nxt; // [RL24]
  end

  // Overvoltage consecutive-cycle counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ov_cnt_r <= '0;
    else if (buck_r != BUCK_SOFT && buck_r != BUCK_RUN)
      ov_cnt_r <= '0;
    else if (tick)
      ov_cnt_r <= sync2_r.over_voltage ? ov_cnt_r + 6'h01 : 6'h00; // [RL24]
  end

  // Restart delay after overcurrent
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      restart_cnt_r <= '0;
    else if (buck_r != BUCK_OC_WAIT)
      restart_cnt_r <= '0;
    else if (tick)
      restart_cnt_r <= restart_cnt_r + 5'h01; // [RL24]
  end

  // Per-cycle switch sequencing; a fresh cycle goes straight to SW_HIGH, from SW_LOW or SW_DEAD, with no dead time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_r <= SW_IDLE;
      dead_cnt_r <= '0;
    end
    else if (buck_r != BUCK_SOFT && buck_r != BUCK_RUN)
    begin
      sw_r <= SW_IDLE; // [RL6]
      dead_cnt_r <= '0;
    end
    else
    begin
      case (sw_r)
        SW_IDLE:
          if (tick)
            sw_r <= SW_HIGH; // [RL7]
        SW_HIGH:
          if (sync2_r.current_peak)
          begin
            sw_r <= SW_DEAD; // [RL7]
            dead_cnt_r <= '0;
          end
          else if (tick)
            sw_r <= SW_HIGH;
        SW_DEAD:
          if (tick)
            sw_r <= SW_HIGH;
          else if (dead_cnt_r == 3'(DEAD_CYC - 1))
            sw_r <= SW_LOW; // [RL7]
          else
            dead_cnt_r <= dead_cnt_r + 3'h1;
        SW_LOW:
          if (tick)
            sw_r <= SW_HIGH; // [RL1] [RL7]
        default:
          sw_r <= SW_IDLE;
      endcase
    end
  end

  // Power stage and buck status outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_side_on <= 1'b0;
      low_side_on <= 1'b0;
      ref_internal <= 1'b0;
      ss_active <= 1'b0;
      buck_output_good <= 1'b0;
      buck_output_bad <= 1'b1;
    end
    else
    begin
      high_side_on <= (sw_r == SW_HIGH) && stage_live; // [RL6] [RL7]
      low_side_on <= (sw_r == SW_LOW) && stage_live; // [RL6] [RL7]
      ref_internal <= (buck_r == BUCK_RUN); // [RL4]
      ss_active <= (buck_r == BUCK_SOFT);
      buck_output_good <= buck_allowed && sync2_r.buck_in_window; // [RL8]
      buck_output_bad <= !(buck_allowed && sync2_r.buck_in_window); // [RL9]
    end
  end

  // Linear regulators, open-drain good pin and shutdown
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      linear_on <= 1'b0;
      linear_output_good_out <= 1'b0;
      linear_output_good_oe_n <= 1'b0;
      chip_shutdown <= 1'b1;
    end
    else
    begin
      linear_on <= sync2_r.linear_regs_enable && !sync2_r.supply_lockout; // [RL21]
      linear_output_good_out <= 1'b0;
      // Pulls low unless enabled and both outputs regulate
      linear_output_good_oe_n <= sync2_r.linear_regs_enable && !sync2_r.supply_lockout
        && sync2_r.linear1_ok && sync2_r.linear2_ok; // [RL15] [RL16]
      chip_shutdown <= !sync2_r.buck_enable && !sync2_r.linear_regs_enable; // [RL22]
    end
  end

  // Reset supervisor; lockout sits below the reset trip so reset is already low
  assign hold_target = 40'(cap_nf_r) * 40'(RST_CYC_PER_NF); // [RL23]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_cnt_r <= '0;
      reset_n_out <= 1'b0;
      reset_out <= 1'b1;
    end
    else if (!sync2_r.supply_ok || sync2_r.supply_lockout)
    begin
      hold_cnt_r <= '0; // [RL17] [RL20]
      reset_n_out <= 1'b0;
      reset_out <= 1'b1;
    end
    else if (hold_cnt_r < hold_target)
      hold_cnt_r <= hold_cnt_r + 40'h1; // [RL17]
    else
    begin
      reset_n_out <= 1'b1; // [RL18]
      reset_out <= 1'b0;
    end
  end

  // APB slave: answer registered in setup, pready in first access cycle
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else if (apb_setup)
    begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= '0;
      if (paddr == CTRL_OFF)
        prdata <= pwrite ? 32'h0 : ctrl_r;
      else if (paddr == CAP_OFF)
        prdata <= pwrite ? 32'h0 : {24'h0, cap_nf_r};
      else if (paddr == STATUS_OFF)
      begin
        if (!pwrite)
        begin
          prdata[ST_PG_BUCK] <= buck_output_good;
          prdata[ST_PG_LIN] <= linear_output_good_oe_n;
          prdata[ST_RESET] <= reset_out;
          prdata[ST_EXT_CLK] <= ext_sel_r;
          prdata[ST_SS] <= ss_active;
          prdata[ST_OV] <= (buck_r == BUCK_OV_LATCH);
          prdata[ST_OC_WAIT] <= (buck_r == BUCK_OC_WAIT);
          prdata[ST_LIN_PIN] <= sync2_r.linear_output_good_in;
          prdata[ST_OC_LSB +: 4] <= oc_cnt_r;
        end
      end
      else
        pslverr <= 1'b1;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= CTRL_RST;
      cap_nf_r <= CAP_NF_RST;
    end
    else if (apb_write && paddr == CTRL_OFF)
      ctrl_r <= {31'h0, pwdata[CTRL_SYNC_EN]};
    else if (apb_write && paddr == CAP_OFF)
      cap_nf_r <= pwdata[7:0];
  end

  // Checks
  sync_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    (buck_r == BUCK_SOFT) |=> !ext_sel_r) // [RL5]
    else $error("external clock selected during soft-start");
  sync_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (buck_r == BUCK_RUN && ctrl_r[CTRL_SYNC_EN] && buck_allowed && sync_rise)
    |=> ext_sel_r) // [RL2]
    else $error("no lock on sync edge");
  loss_fallback_a: assert property (@(posedge pclk) disable iff (!presetn)
    (loss_cnt_r == 10'(LOSS_CYC - 1) && !sync_rise) |=> !ext_sel_r) // [RL3]
    else $error("no fallback after lost sync");
  switch_overlap_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(high_side_on && low_side_on) and (sw_r == SW_DEAD |=> !low_side_on)) // [RL7]
    else $error("switch overlap or dead time skipped");
  buck_good_a: assert property (@(posedge pclk) disable iff (!presetn)
    !buck_allowed |=> !buck_output_good) // [RL8]
    else $error("buck good high while disabled");
  good_inverse_a: assert property (@(posedge pclk) disable iff (!presetn)
    buck_output_bad == !buck_output_good) // [RL9]
    else $error("buck good outputs not complementary");
  oc_saturate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && buck_r == BUCK_RUN && buck_allowed && !sync2_r.over_current
     && oc_cnt_r == 4'h0) |=> oc_cnt_r == 4'h0) // [RL10]
    else $error("overcurrent counter wrapped below zero");
  oc_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && buck_allowed && buck_r == BUCK_RUN && oc_nxt == OC_MAX && !sync2_r.over_voltage)
    |=> buck_r == BUCK_OC_WAIT && ss_cnt_r == 13'h0) // [RL11]
    else $error("no shutdown at full overcurrent count");
  ov_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (buck_r == BUCK_OV_LATCH && buck_allowed) |=> buck_r == BUCK_OV_LATCH) // [RL14]
    else $error("overvoltage latch left without toggle");
  reset_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    (reset_n_out != reset_out) and (!sync2_r.supply_ok |=> !reset_n_out)) // [RL17] [RL18]
    else $error("reset outputs wrong");
  shutdown_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!sync2_r.buck_enable && !sync2_r.linear_regs_enable)
    |=> chip_shutdown && !linear_on && !high_side_on) // [RL22]
    else $error("full shutdown not reached");

endmodule

// ---- shared/rail_seq_pkg.sv ----
// Constants, register map and types for the regulator supervision block
package rail_seq_pkg;
  // Clock and time base
  localparam int CLK_MHZ = 200;
  localparam int INT_OSC_KHZ = 750;
  localparam int INT_PERIOD_CYC = CLK_MHZ * 1000 / INT_OSC_KHZ;
  localparam int INT_CLK_NS = 1300;
  localparam int LOSS_CYC = 2 * INT_CLK_NS * CLK_MHZ / 1000;
  localparam int DEAD_NS = 20;
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int SS_TIME_US = 5500;
  localparam int SS_CYC_DEF = SS_TIME_US * INT_OSC_KHZ / 1000;
  localparam int RST_US_PER_NF = 2500;
  localparam int RST_CYC_PER_NF_DEF = RST_US_PER_NF * CLK_MHZ;
  // Protection counts, in switching cycles
  localparam logic [3:0] OC_MAX = 4'hf;
  localparam logic [3:0] OC_UP = 4'h2;
  localparam logic [4:0] RESTART_CLKS = 5'h10;
  localparam logic [5:0] OV_CLKS = 6'h20;
  // Register offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] CAP_OFF = 12'h004;
  localparam logic [11:0] STATUS_OFF = 12'h008;
  // Field positions and reset values
  localparam int CTRL_SYNC_EN = 0;
  localparam logic [31:0] CTRL_RST = 32'h00000001;
  localparam logic [7:0] CAP_NF_RST = 8'h0a;
  localparam int ST_PG_BUCK = 0;
  localparam int ST_PG_LIN = 1;
  localparam int ST_RESET = 2;
  localparam int ST_EXT_CLK = 3;
  localparam int ST_SS = 4;
  localparam int ST_OV = 5;
  localparam int ST_OC_WAIT = 6;
  localparam int ST_LIN_PIN = 7;
  localparam int ST_OC_LSB = 8;

  typedef struct packed {
    logic buck_enable;
    logic linear_regs_enable;
    logic sync_clk;
    logic supply_ok;
    logic supply_lockout;
    logic buck_in_window;
    logic current_peak;
    logic over_current;
    logic over_voltage;
    logic linear1_ok;
    logic linear2_ok;
    logic linear_output_good_in;
  } pin_in_type;

  typedef enum logic [4:0] {
    BUCK_OFF = 5'h01,
    BUCK_SOFT = 5'h02,
    BUCK_RUN = 5'h04,
    BUCK_OC_WAIT = 5'h08,
    BUCK_OV_LATCH = 5'h10
  } buck_state_type;

  typedef enum logic [3:0] {
    SW_IDLE = 4'h1,
    SW_HIGH = 4'h2,
    SW_DEAD = 4'h4,
    SW_LOW = 4'h8
  } sw_state_type;
endpackage

// ---- test/host_side_model.sv ----
// Host side: external sync clock source and the pulled-up linear good line
`timescale 1ns/1ps
module host_side_model
#(
  parameter int HALF_CYC = 125
)
(
  // Clock
  input wire logic pclk,
  // Bench control
  input wire logic sync_run,
  // Open-drain line from the block
  input wire logic good_out,
  input wire logic good_oe_n,
  // Towards the block
  output logic sync_clk,
  output logic good_wire
);
  int cnt;
  // 125 pclk per half period is 800kHz, inside the allowed band
  always_ff @(posedge pclk)
  begin
    if (!sync_run)
    begin
      cnt <= 0;
      sync_clk <= 1'b0; // Stands still between bursts
    end
    else if (cnt == HALF_CYC - 1)
    begin
      cnt <= 0;
      sync_clk <= ~sync_clk;
    end
    else
      cnt <= cnt + 1;
  end
  // Pull-up wins once the block lets go
  assign good_wire = good_oe_n ? 1'b1 : good_out;
endmodule

// ---- test/buck_fault_sync_sequencer_tb_top.sv ----
// Self-checking bench for the regulator supervision block
`timescale 1ns/1ps
module buck_fault_sync_sequencer_tb_top
  import rail_seq_pkg::*;
;
  localparam int TICK = INT_PERIOD_CYC;
  localparam int SSC = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pin_in_type p, pins_w;
  logic hs, ls, ref_int, ss, bg, bb, lg_out, lg_oe_n, lin_on, shut, rst_n, rst;
  logic sync_run, sync_w, lg_wire;
  int num_errors, n_checks;

  always_comb
  begin
    pins_w = p;
    pins_w.sync_clk = sync_w;
    pins_w.linear_output_good_in = lg_wire;
  end

  rail_supervisor #(.SS_CYC(SSC), .RST_CYC_PER_NF(10)) rail_supervisor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins_w), .high_side_on(hs), .low_side_on(ls), .ref_internal(ref_int),
    .ss_active(ss), .buck_output_good(bg), .buck_output_bad(bb),
    .linear_output_good_out(lg_out), .linear_output_good_oe_n(lg_oe_n),
    .linear_on(lin_on), .chip_shutdown(shut), .reset_n_out(rst_n), .reset_out(rst));

  host_side_model host_side_model_i (
    .pclk(pclk), .sync_run(sync_run), .good_out(lg_out), .good_oe_n(lg_oe_n),
    .sync_clk(sync_w), .good_wire(lg_wire));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic hang(input string what);
    chk(what, 32'h0, 32'h1);
    finish_test();
  endtask

  // Request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      hang("apb wait");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls status; each poll spans three clocks
  task automatic wait_st(input int b, input logic v, input int lim, output int k);
    k = 0;
    do
    begin
      apb(1'b0, STATUS_OFF, 32'h0);
      k++;
    end
    while (rd[b] !== v && k < lim);
    if (rd[b] !== v)
      hang("status wait");
  endtask

  task automatic wait_lvl(input bit low, input logic v, inout int n);
    int k;
    for (k = 0; (low ? ls : hs) !== v; k++)
    begin
      if (k > 2000)
        hang("switch wait");
      if (hs === 1'b1 && ls === 1'b1)
        chk("shoot through", 32'h1, 32'h0);
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic t_regs();
    apb(1'b0, CTRL_OFF, 32'h0);
    chk("ctrl reset", rd, CTRL_RST);
    apb(1'b0, CAP_OFF, 32'h0);
    chk("cap reset", rd, {24'h0, CAP_NF_RST});
    apb(1'b1, CAP_OFF, 32'h00000002);
    apb(1'b1, STATUS_OFF, 32'hffffffff);
    apb(1'b0, CAP_OFF, 32'h0);
    chk("cap rw", rd, 32'h00000002);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask

  task automatic t_rst();
    int n;
    p.supply_ok <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("rst low supply", {rst_n, rst}, 2'b01);
    p.supply_ok <= 1'b1;
    for (n = 0; rst_n !== 1'b1 && n < 100; n++)
      @(posedge pclk);
    chk("rst hold", n >= 20 && n <= 28, 1'b1);
    chk("rst pair", {rst_n, rst}, 2'b10);
  endtask

  task automatic t_soft();
    int k;
    p.buck_enable <= 1'b1;
    p.buck_in_window <= 1'b1;
    sync_run <= 1'b1;
    wait_st(ST_SS, 1'b1, 20, k);
    repeat (1000) @(posedge pclk);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("ext in soft", rd[ST_EXT_CLK], 1'b0);
    wait_st(ST_SS, 1'b0, 3000, k);
    k = k * 3 + 1000;
    chk("soft len", k > (SSC - 1) * TICK && k < (SSC + 1) * TICK, 1'b1);
    chk("ref", ref_int, 1'b1);
    apb(1'b1, CTRL_OFF, 32'h0);
    repeat (300) @(posedge pclk);
    apb(1'b0, CTRL_OFF, 32'h0);
    chk("ctrl rw", rd, 32'h0);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("sync disabled", rd[ST_EXT_CLK], 1'b0);
    apb(1'b1, CTRL_OFF, 32'h1);
    wait_st(ST_EXT_CLK, 1'b1, 150, k);
    chk("ext lock", rd[ST_EXT_CLK], 1'b1);
    chk("good", {bg, bb}, 2'b10);
    p.buck_in_window <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("out of window", {bg, bb}, 2'b01);
    p.buck_in_window <= 1'b1;
    sync_run <= 1'b0;
    wait_st(ST_EXT_CLK, 1'b0, 300, k);
    chk("fallback", k * 3 >= 260 && k * 3 <= 540, 1'b1);
    chk("no break", ref_int, 1'b1);
  endtask

  task automatic t_switch();
    int n, gap;
    n = 0;
    // High side holds until a peak, so end it first, then catch a cycle start
    p.current_peak <= 1'b1;
    @(posedge pclk);
    p.current_peak <= 1'b0;
    wait_lvl(1'b1, 1'b1, n);
    wait_lvl(1'b1, 1'b0, n);
    n = 0;
    p.current_peak <= 1'b1;
    @(posedge pclk);
    n++;
    p.current_peak <= 1'b0;
    wait_lvl(1'b0, 1'b0, n);
    gap = n;
    wait_lvl(1'b1, 1'b1, n);
    chk("dead time", n - gap >= DEAD_CYC, 1'b1);
    wait_lvl(1'b1, 1'b0, n);
    wait_lvl(1'b0, 1'b1, n);
    chk("cycle period", n, TICK);
  endtask

  task automatic t_oc();
    int k;
    p.over_current <= 1'b1;
    wait_st(ST_OC_WAIT, 1'b1, 1000, k);
    chk("oc trip", k * 3 >= 7 * TICK && k * 3 <= 8 * TICK + 12, 1'b1);
    chk("oc off", {hs, ls, rd[ST_SS]}, 3'b000);
    p.over_current <= 1'b0;
    wait_st(ST_SS, 1'b1, 2000, k);
    chk("oc restart", k * 3 >= 16 * TICK - 10 && k * 3 <= 16 * TICK + 10, 1'b1);
    wait_st(ST_SS, 1'b0, 3000, k);
  endtask

  task automatic t_ov();
    int k;
    p.over_voltage <= 1'b1;
    repeat (20 * TICK) @(posedge pclk);
    p.over_voltage <= 1'b0;
    repeat (2 * TICK) @(posedge pclk);
    p.over_voltage <= 1'b1;
    wait_st(ST_OV, 1'b1, 4000, k);
    chk("ov count", k * 3 >= 31 * TICK - 3 && k * 3 <= 32 * TICK + 12, 1'b1);
    chk("ov off", {hs, ss, ref_int}, 3'b000);
    p.over_voltage <= 1'b0;
    repeat (20 * TICK) @(posedge pclk);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("ov latch", {rd[ST_OV], rd[ST_SS]}, 2'b10);
    p.buck_enable <= 1'b0; // Toggle that frees the latch
    repeat (8) @(posedge pclk);
    chk("buck off", {hs, ls, ss, bg, bb}, 5'b00001);
    p.buck_enable <= 1'b1;
    wait_st(ST_SS, 1'b1, 20, k);
    chk("ov cleared", rd[ST_OV], 1'b0);
  endtask

  task automatic t_lock();
    int k;
    p.supply_ok <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("rst first", {rst_n, ss}, 2'b01);
    p.supply_lockout <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("lockout", {hs, ss, ref_int, rst_n}, 4'h0);
    p.supply_lockout <= 1'b0;
    p.supply_ok <= 1'b1;
    wait_st(ST_SS, 1'b1, 20, k);
    chk("relaunch", rd[ST_SS], 1'b1);
  endtask

  task automatic t_lin();
    p.linear_regs_enable <= 1'b1;
    p.linear1_ok <= 1'b1;
    p.linear2_ok <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("lin up", {lin_on, lg_oe_n, shut}, 3'b110);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("lin pin up", rd[ST_LIN_PIN], 1'b1);
    p.linear2_ok <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("lin bad", lg_oe_n, 1'b0);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("lin pin bad", rd[ST_LIN_PIN], 1'b0);
    p.linear2_ok <= 1'b1;
    p.linear_regs_enable <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("lin off", {lin_on, lg_oe_n, lg_out, ss}, 4'b0001);
    p.buck_enable <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("chip off", {shut, hs, ls}, 3'b100);
  endtask

  initial
  begin
    num_errors = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sync_run = 1'b0;
    p = '0;
    p.supply_ok = 1'b1;
    repeat (20) @(posedge pclk);
    chk("in reset", {rst_n, rst, bb, shut}, 4'h7);
    presetn <= 1'b1;
    t_regs();
    t_rst();
    t_soft();
    t_switch();
    t_oc();
    t_ov();
    t_lock();
    t_lin();
    finish_test();
  end
endmodule
